// file: hw/rpcs_pkg.sv
// Register map, field layout and reset values of the receiver PLL registers.
package rpcs_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int          ADDR_W       = 8;
   localparam int          DATA_W       = 32;
   localparam int          IDX_W        = 6;
   localparam int          EVENT_W      = 2;

   // ----------------------------------------------------------------
   // Register indices; the byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [5:0]  IDX_CTRL     = 6'h0e;
   localparam logic [5:0]  IDX_CFG1     = 6'h0f;
   localparam logic [5:0]  IDX_CFG2     = 6'h10;
   localparam logic [5:0]  IDX_CFG3     = 6'h11;
   localparam logic [5:0]  IDX_DETECT   = 6'h12;
   localparam logic [5:0]  IDX_ISTAT    = 6'h30;
   localparam logic [5:0]  IDX_IMASK    = 6'h31;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int          FREE_RUN_BIT = 4;
   localparam int          PDIV_LSB     = 4;
   localparam int          JHI_LSB      = 0;
   localparam int          JLO_LSB      = 6;
   localparam int          DHI_LSB      = 0;
   localparam int          COMP_BIT     = 0;
   localparam int          SURR_BIT     = 1;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_CTRL     = 8'h00;
   localparam logic [7:0]  RST_CFG1     = 8'h18;
   localparam logic [7:0]  RST_CFG2     = 8'h00;
   localparam logic [7:0]  RST_CFG3     = 8'h00;
   localparam logic [1:0]  RST_MASK     = 2'h0;
   localparam logic [1:0]  RST_STATUS   = 2'h0;

endpackage

// file: hw/rpcs_sync.sv
// Two-flop synchroniser for a group of pin levels.
`timescale 1ns/1ps

module rpcs_sync #(
   parameter int WIDTH = 3
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             srst,
   // Levels in and out.
   input  wire logic [WIDTH-1:0] pinIn,
   output wire logic [WIDTH-1:0] levelOut
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } rpcs_sync_type;

   rpcs_sync_type syncReg;
   rpcs_sync_type syncNext;

   // The first stage feeds only the second stage.
   always_comb begin
      syncNext.stage1 = pinIn;
      syncNext.stage2 = syncReg.stage1;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         syncReg <= '0;
      end else begin
         syncReg <= syncNext;
      end
   end

   assign levelOut = syncReg.stage2;

endmodule

// file: hw/rpcs_event.sv
// Sticky event bits set on rising flags and cleared by writing ones.
`timescale 1ns/1ps

module rpcs_event
   import rpcs_pkg::*;
#(
   parameter int WIDTH = EVENT_W
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             srst,
   // Flags and clear.
   input  wire logic [WIDTH-1:0] flagLevel,
   input  wire logic [WIDTH-1:0] clearBits,
   // Sticky status.
   output wire logic [WIDTH-1:0] eventStatus
);

   typedef struct packed {
      logic [WIDTH-1:0] prev;
      logic [WIDTH-1:0] status;
   } rpcs_event_type;

   rpcs_event_type evReg;
   rpcs_event_type evNext;

   // A new event in the clearing cycle survives the clear.
   always_comb begin
      evNext.prev   = flagLevel;
      evNext.status = (evReg.status & ~clearBits)
                    | (flagLevel & ~evReg.prev);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         evReg <= '0;
      end else begin
         evReg <= evNext;
      end
   end

   assign eventStatus = evReg.status;

endmodule

// file: hw/rpcs_top.sv
// APB register bank for receiver PLL control and non-PCM detection.
`timescale 1ns/1ps

module rpcs_top
   import rpcs_pkg::*;
(
   // Clock and reset.
   input  wire logic              clk,
   input  wire logic              srst,
   // APB slave.
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output wire logic [DATA_W-1:0] prdata,
   output wire logic              pready,
   output wire logic              pslverr,
   // Detector and lock pins.
   input  wire logic              compDetect,
   input  wire logic              surroundDetect,
   input  wire logic              pllLocked,
   // Clock control outputs.
   output wire logic              recClkRun,
   output wire logic [3:0]        preDivider,
   output wire logic [5:0]        intMult,
   output wire logic [13:0]       fracMult,
   // Interrupt.
   output wire logic              irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]        ctrl;
      logic [7:0]        cfg1;
      logic [7:0]        cfg2;
      logic [7:0]        cfg3;
      logic [1:0]        mask;
      logic              ready;
      logic              err;
      logic [DATA_W-1:0] rdata;
      logic              clkRun;
      logic              irq;
   } rpcs_state_type;

   rpcs_state_type stateReg;
   rpcs_state_type stateNext;

   logic [2:0]         pinSync;
   logic [EVENT_W-1:0] eventStatus;
   logic [EVENT_W-1:0] clearBits;
   logic               accStart;
   logic               accDone;
   logic               wrDone;
   logic [1:0]         detectFlags;
   logic               lockSync;

   // ----------------------------------------------------------------
   // Address decoding
   // ----------------------------------------------------------------
   function automatic logic regHit(input logic [ADDR_W-1:0] addr,
                                   input logic [IDX_W-1:0]  idx);
      regHit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
   endfunction

   function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
      isMapped = regHit(addr, IDX_CTRL)  || regHit(addr, IDX_CFG1)
              || regHit(addr, IDX_CFG2)  || regHit(addr, IDX_CFG3)
              || regHit(addr, IDX_DETECT) || regHit(addr, IDX_ISTAT)
              || regHit(addr, IDX_IMASK);
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisation and event capture
   // ----------------------------------------------------------------
   rpcs_sync #(
      .WIDTH    (3)
   ) u_sync (
      .clk      (clk),
      .srst     (srst),
      .pinIn    ({pllLocked, surroundDetect, compDetect}),
      .levelOut (pinSync)
   );

   assign detectFlags = pinSync[1:0];
   assign lockSync    = pinSync[2];

   rpcs_event #(
      .WIDTH       (EVENT_W)
   ) u_event (
      .clk         (clk),
      .srst        (srst),
      .flagLevel   (detectFlags),
      .clearBits   (clearBits),
      .eventStatus (eventStatus)
   );

   // ----------------------------------------------------------------
   // Bus phases
   // ----------------------------------------------------------------
   // Every access takes one wait state; it completes on the second
   // access edge, when pready is already high.
   assign accStart  = psel && penable && !stateReg.ready;
   assign accDone   = psel && penable && stateReg.ready;
   assign wrDone    = accDone && pwrite;
   assign clearBits = (wrDone && regHit(paddr, IDX_ISTAT))
                    ? pwdata[EVENT_W-1:0] : '0;

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   function automatic logic [DATA_W-1:0] readValue(
         input logic [ADDR_W-1:0] addr,
         input rpcs_state_type    st,
         input logic [1:0]        flags,
         input logic [1:0]        evs);
      logic [DATA_W-1:0] v;
      v = '0;
      if (regHit(addr, IDX_CTRL)) begin
         v[FREE_RUN_BIT] = st.ctrl[FREE_RUN_BIT];
      end
      if (regHit(addr, IDX_CFG1)) begin
         v[7:0] = st.cfg1;
      end
      if (regHit(addr, IDX_CFG2)) begin
         v[7:0] = st.cfg2;
      end
      if (regHit(addr, IDX_CFG3)) begin
         v[7:0] = st.cfg3;
      end
      if (regHit(addr, IDX_DETECT)) begin
         v[COMP_BIT] = flags[COMP_BIT];
         v[SURR_BIT] = flags[SURR_BIT];
      end
      if (regHit(addr, IDX_ISTAT)) begin
         v[1:0] = evs;
      end
      if (regHit(addr, IDX_IMASK)) begin
         v[1:0] = st.mask;
      end
      readValue = v;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      stateNext = stateReg;
      if (accStart) begin
         stateNext.ready = 1'b1;
         stateNext.err   = !isMapped(paddr);
         stateNext.rdata = pwrite ? '0
                         : readValue(paddr, stateReg, detectFlags,
                                     eventStatus);
      end
      if (accDone) begin
         stateNext.ready = 1'b0;
         stateNext.err   = 1'b0;
      end
      if (wrDone) begin
         if (regHit(paddr, IDX_CTRL)) begin
            stateNext.ctrl = pwdata[7:0] & (8'h01 << FREE_RUN_BIT);
         end
         if (regHit(paddr, IDX_CFG1)) begin
            stateNext.cfg1 = pwdata[7:0];
         end
         if (regHit(paddr, IDX_CFG2)) begin
            stateNext.cfg2 = pwdata[7:0];
         end
         if (regHit(paddr, IDX_CFG3)) begin
            stateNext.cfg3 = pwdata[7:0];
         end
         if (regHit(paddr, IDX_IMASK)) begin
            stateNext.mask = pwdata[1:0];
         end
         // The detection register has no storage, so a write is lost.
      end
      stateNext.clkRun = lockSync || stateReg.ctrl[FREE_RUN_BIT];
      stateNext.irq    = |(eventStatus & stateReg.mask);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         stateReg.ctrl   <= RST_CTRL;
         stateReg.cfg1   <= RST_CFG1;
         stateReg.cfg2   <= RST_CFG2;
         stateReg.cfg3   <= RST_CFG3;
         stateReg.mask   <= RST_MASK;
         stateReg.ready  <= 1'b0;
         stateReg.err    <= 1'b0;
         stateReg.rdata  <= '0;
         stateReg.clkRun <= 1'b0;
         stateReg.irq    <= 1'b0;
      end else begin
         stateReg <= stateNext;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata     = stateReg.rdata;
   assign pready     = stateReg.ready;
   assign pslverr    = stateReg.err;
   assign recClkRun  = stateReg.clkRun;
   assign irq        = stateReg.irq;
   assign preDivider = stateReg.cfg1[PDIV_LSB +: 4];
   assign intMult    = {stateReg.cfg1[JHI_LSB +: 4],
                        stateReg.cfg2[JLO_LSB +: 2]};
   assign fracMult   = {stateReg.cfg2[DHI_LSB +: 6],
                        stateReg.cfg3};

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking

   default disable iff (srst);

   sequence accessStartSeq;
      psel && penable && !pready;
   endsequence

   sequence writeDoneSeq(logic [IDX_W-1:0] idx);
      psel && penable && pready && pwrite && regHit(paddr, idx);
   endsequence

   sequence readStartSeq(logic [IDX_W-1:0] idx);
      psel && penable && !pready && !pwrite && regHit(paddr, idx);
   endsequence

   chk_access_wait: assert property (
      accessStartSeq |=> pready ##1 !pready)
      else $error("access did not answer after one wait state");

   chk_unlock_stop: assert property (
      (!stateReg.ctrl[FREE_RUN_BIT] && !lockSync) |=> !recClkRun)
      else $error("recovered clock not stopped on loss of lock");

   chk_free_run: assert property (
      stateReg.ctrl[FREE_RUN_BIT] |=> recClkRun)
      else $error("recovered clock not free running");

   chk_pdiv_write: assert property (
      writeDoneSeq(IDX_CFG1) |=>
         preDivider == $past(pwdata[7:4])
         && intMult[5:2] == $past(pwdata[3:0]))
      else $error("pre-divider or high multiplier not taken");

   chk_jlow_write: assert property (
      writeDoneSeq(IDX_CFG2) |=>
         intMult[1:0] == $past(pwdata[7:6])
         && fracMult[13:8] == $past(pwdata[5:0]))
      else $error("low multiplier or high fraction not taken");

   chk_dfrac_write: assert property (
      writeDoneSeq(IDX_CFG3) |=> fracMult[7:0] == $past(pwdata[7:0]))
      else $error("low fraction not taken");

   chk_comp_flag: assert property (
      readStartSeq(IDX_DETECT) |=>
         prdata[COMP_BIT] == $past(detectFlags[COMP_BIT]))
      else $error("compressed stream flag misread");

   chk_surr_flag: assert property (
      readStartSeq(IDX_DETECT) |=>
         prdata[SURR_BIT] == $past(detectFlags[SURR_BIT]))
      else $error("surround disc flag misread");

   chk_detect_zero: assert property (
      readStartSeq(IDX_DETECT) |=> prdata[DATA_W-1:2] == '0)
      else $error("upper detection bits not zero");

   chk_ro_write: assert property (
      writeDoneSeq(IDX_DETECT) |=> $stable(stateReg.cfg3)
         && $stable(stateReg.ctrl) && $stable(stateReg.mask))
      else $error("write to detection register changed state");

   chk_irq_level: assert property (
      |(eventStatus & stateReg.mask) |=> irq)
      else $error("interrupt not raised for unmasked event");

endmodule

// file: tb/receiver_pll_config_status_tb_top.sv
// Self-checking testbench for the receiver PLL register bank.
`timescale 1ns/1ps

module receiver_pll_config_status_tb_top
   import rpcs_pkg::*;
;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic              clk;
   logic              srst;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata;
   logic [DATA_W-1:0] prdata;
   logic              pready;
   logic              pslverr;
   logic              compDetect;
   logic              surroundDetect;
   logic              pllLocked;
   logic              recClkRun;
   logic [3:0]        preDivider;
   logic [5:0]        intMult;
   logic [13:0]       fracMult;
   logic              irq;
   int                n_fail;
   int                cmp_count;
   int                cycles;

   rpcs_top u_rpcs_top (
      .clk            (clk),
      .srst           (srst),
      .psel           (psel),
      .penable        (penable),
      .pwrite         (pwrite),
      .paddr          (paddr),
      .pwdata         (pwdata),
      .prdata         (prdata),
      .pready         (pready),
      .pslverr        (pslverr),
      .compDetect     (compDetect),
      .surroundDetect (surroundDetect),
      .pllLocked      (pllLocked),
      .recClkRun      (recClkRun),
      .preDivider     (preDivider),
      .intMult        (intMult),
      .fracMult       (fracMult),
      .irq            (irq)
   );

   // ----------------------------------------------------------------
   // Clock, timeout and verdict
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic give_verdict();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // The whole sequence needs well under a thousand cycles.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_fail = n_fail + 1;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; holds the request until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic expErr);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, rd, err);
      chk({31'h0, err}, {31'h0, expErr});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input logic expErr);
      logic [31:0] d;
      logic        err;
      apb(1'b0, a, 32'h0, d, err);
      chk(d, exp);
      chk({31'h0, err}, {31'h0, expErr});
   endtask

   task automatic wait_cycles(input int n);
      repeat (n) @(posedge clk);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_values();
      rd(8'h38, 32'h0, 1'b0);
      rd(8'h3c, 32'h18, 1'b0);
      rd(8'h40, 32'h0, 1'b0);
      rd(8'h44, 32'h0, 1'b0);
      rd(8'h48, 32'h0, 1'b0);
      chk({8'h0, preDivider, intMult, fracMult}, {8'h0, 4'h1, 6'h20, 14'h0});
      chk({31'h0, recClkRun}, 32'h0);
   endtask

   // P=2, J=7, D=2818, then P=1, J=8, D=7075, over the three words.
   task automatic t_pll_fields();
      wr(8'h3c, 32'hffff_ff21, 1'b0);
      wr(8'h40, 32'h0000_00cb, 1'b0);
      wr(8'h44, 32'h0000_0002, 1'b0);
      wait_cycles(1);
      chk({28'h0, preDivider}, 32'h2);
      chk({26'h0, intMult}, 32'd7);
      chk({18'h0, fracMult}, 32'd2818);
      rd(8'h3c, 32'h21, 1'b0);
      rd(8'h40, 32'hcb, 1'b0);
      rd(8'h44, 32'h02, 1'b0);
      wr(8'h3c, 32'h0000_0012, 1'b0);
      wr(8'h40, 32'h0000_001b, 1'b0);
      wr(8'h44, 32'h0000_00a3, 1'b0);
      wait_cycles(1);
      chk({8'h0, preDivider, intMult, fracMult},
          {8'h0, 4'h1, 6'h08, 14'h1ba3});
   endtask

   task automatic t_unlock_mode();
      pllLocked <= 1'b1;
      wait_cycles(6);
      chk({31'h0, recClkRun}, 32'h1);
      pllLocked <= 1'b0;
      wait_cycles(6);
      chk({31'h0, recClkRun}, 32'h0);
      wr(8'h38, 32'h0000_00ff, 1'b0);
      rd(8'h38, 32'h10, 1'b0);
      wait_cycles(1);
      chk({31'h0, recClkRun}, 32'h1);
      wr(8'h38, 32'h0, 1'b0);
      wait_cycles(2);
      chk({31'h0, recClkRun}, 32'h0);
   endtask

   task automatic t_detect_irq();
      compDetect <= 1'b1;
      wait_cycles(6);
      rd(8'h48, 32'h1, 1'b0);
      chk({31'h0, irq}, 32'h0);
      rd(8'hc0, 32'h1, 1'b0);
      wr(8'hc4, 32'h1, 1'b0);
      wait_cycles(2);
      chk({31'h0, irq}, 32'h1);
      wr(8'hc0, 32'h1, 1'b0);
      wait_cycles(2);
      chk({31'h0, irq}, 32'h0);
      rd(8'hc0, 32'h0, 1'b0);
      surroundDetect <= 1'b1;
      wait_cycles(6);
      rd(8'h48, 32'h3, 1'b0);
      rd(8'hc0, 32'h2, 1'b0);
      chk({31'h0, irq}, 32'h0);
      wr(8'hc4, 32'h2, 1'b0);
      wait_cycles(2);
      chk({31'h0, irq}, 32'h1);
      wr(8'h48, 32'hffff_ffff, 1'b0);
      rd(8'h48, 32'h3, 1'b0);
      compDetect <= 1'b0;
      wait_cycles(6);
      rd(8'h48, 32'h2, 1'b0);
      surroundDetect <= 1'b0;
      wait_cycles(6);
      rd(8'h48, 32'h0, 1'b0);
      wr(8'hc0, 32'h3, 1'b0);
      wait_cycles(2);
      chk({31'h0, irq}, 32'h0);
   endtask

   task automatic t_bad_address();
      wr(8'h00, 32'h55, 1'b1);
      rd(8'h00, 32'h0, 1'b1);
      wr(8'h3d, 32'h00, 1'b1);
      rd(8'h3c, 32'h12, 1'b0);
      rd(8'h4c, 32'h0, 1'b1);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      n_fail = 0;
      cmp_count = 0;
      cycles = 0;
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      compDetect = 1'b0;
      surroundDetect = 1'b0;
      pllLocked = 1'b0;
      wait_cycles(20);
      srst <= 1'b0;
      t_reset_values();
      t_pll_fields();
      t_unlock_mode();
      t_detect_irq();
      t_bad_address();
      wait_cycles(2);
      give_verdict();
   end

endmodule
